// [core/pie_enable_bank.sv]
// peripheral interrupt enable bank with flags and core request gating
// assumes apb master on clk_i and source event pulses on clk_i
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - bit 7 gates parallel port request
// - bit 6 gates conversion-complete request
// - bit 5 gates serial receive request
// - bit 4 gates serial transmit request
// - bit 1 gates timer two match
// - bit 0 gates timer one overflow
// - peripheral group enable also required
// - flags set regardless of any enable
// - global enable gates every request
module pie_enable_bank
  import pie_pkg::*;
#(
  parameter bit HAS_PAR_PORT = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [PIE_ADDR_W-1:0] paddr_i,
  input wire logic [PIE_DATA_W-1:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [PIE_DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [PIE_SRC_N-1:0] event_i,
  output logic [PIE_SRC_N-1:0] flags_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // one-hot: [2] enables, [1] flags, [0] core control
  function automatic logic [2:0] reg_sel(input logic [PIE_ADDR_W-1:0] a);
    logic [2:0] s;
    s = 3'h0;
    s[0] = (a == PIE_OFF_CORE_CTL);
    s[1] = (a == PIE_OFF_FLAGS);
    s[2] = (a == PIE_OFF_ENABLES);
    return s;
  endfunction

  logic [7:0] en_q;
  logic [7:0] en_d;
  logic gie_q;
  logic gie_d;
  logic periph_group_irq_en_q;
  logic periph_group_irq_en_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [PIE_DATA_W-1:0] prdata_q;
  logic [PIE_DATA_W-1:0] prdata_d;
  logic irq_q;
  logic irq_d;
  logic [PIE_SRC_N-1:0] flags;
  logic [PIE_SRC_N-1:0] flag_clr;
  logic [2:0] setup_sel;
  logic [2:0] acc_sel;
  logic setup;
  logic wr_acc;
  logic [7:0] en_mask;

  assign setup = psel_i & ~penable_i;
  assign wr_acc = psel_i & penable_i & pready_q & pwrite_i & pstrb_i[0];
  assign setup_sel = reg_sel(paddr_i);
  assign acc_sel = reg_sel(paddr_i);
  // without the parallel port bit 7 is not stored and reads zero
  assign en_mask = HAS_PAR_PORT ? 8'hff : 8'h7f;

  // ---------------------------------------------------------------
  // flags
  // ---------------------------------------------------------------
  // events set flags whatever the enables say
  pie_flag_bank u_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(event_i),
    .clr_i(flag_clr),
    .flags_o(flags)
  );

  // write one to clear
  assign flag_clr = (wr_acc && acc_sel[1]) ? pwdata_i[7:0] : 8'h00;

  // ---------------------------------------------------------------
  // register file and apb answer
  // ---------------------------------------------------------------
  // read data sampled in the setup cycle; answer in the first access cycle
  always_comb begin
    en_d = en_q;
    gie_d = gie_q;
    periph_group_irq_en_d = periph_group_irq_en_q;
    pready_d = setup;
    pslverr_d = setup & ~(|setup_sel);
    prdata_d = prdata_q;
    if (setup) begin
      prdata_d = '0;
      case (setup_sel)
        3'b001: begin
          prdata_d[PIE_BIT_GLOBAL_EN] = gie_q;
          prdata_d[PIE_BIT_PERIPH_EN] = periph_group_irq_en_q;
        end
        3'b010: begin
          prdata_d[7:0] = flags;
        end
        3'b100: begin
          prdata_d[7:0] = en_q;
        end
        default: begin
          prdata_d = '0;
        end
      endcase
    end
    if (wr_acc && acc_sel[2]) begin
      en_d = pwdata_i[7:0] & en_mask;
    end
    if (wr_acc && acc_sel[0]) begin
      gie_d = pwdata_i[PIE_BIT_GLOBAL_EN];
      periph_group_irq_en_d = pwdata_i[PIE_BIT_PERIPH_EN];
    end
  end

  // ---------------------------------------------------------------
  // core request
  // ---------------------------------------------------------------
  // each source passes only with its own, group and global enables
  always_comb begin
    irq_d = (|(flags & en_q)) & periph_group_irq_en_q & gie_q;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_q <= PIE_RST_ENABLES;
      gie_q <= PIE_RST_CORE_CTL[PIE_BIT_GLOBAL_EN];
      periph_group_irq_en_q <= PIE_RST_CORE_CTL[PIE_BIT_PERIPH_EN];
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      irq_q <= 1'b0;
    end else begin
      en_q <= en_d;
      gie_q <= gie_d;
      periph_group_irq_en_q <= periph_group_irq_en_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      irq_q <= irq_d;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign irq_o = irq_q;
  assign flags_o = flags;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // lone flag k: request next cycle follows its full enable chain
  property p_gate(int k);
    (flags == (8'h01 << k)) |=>
      (irq_o == $past(en_q[k] & periph_group_irq_en_q & gie_q));
  endproperty

  par_port_gate_a: assert property (p_gate(7))
    else $error("parallel port request gating wrong");
  conv_done_gate_a: assert property (p_gate(6))
    else $error("conversion request gating wrong");
  serial_rx_gate_a: assert property (p_gate(5))
    else $error("serial receive request gating wrong");
  serial_tx_gate_a: assert property (p_gate(4))
    else $error("serial transmit request gating wrong");
  timer_two_gate_a: assert property (p_gate(1))
    else $error("timer two request gating wrong");
  timer_one_gate_a: assert property (p_gate(0))
    else $error("timer one request gating wrong");
  sync_serial_gate_a: assert property (p_gate(3))
    else $error("sync serial request gating wrong");
  capcmp_gate_a: assert property (p_gate(2))
    else $error("capcmp request gating wrong");
  periph_group_a: assert property (!periph_group_irq_en_q |=> !irq_o)
    else $error("request passed with group enable clear");
  global_enable_a: assert property (!gie_q |=> !irq_o)
    else $error("request passed with global enable clear");
  flag_set_a: assert property (
    (|event_i) |=> ((flags & $past(event_i)) == $past(event_i)))
    else $error("event did not set its flag");
  reserved_bit_a: assert property (!HAS_PAR_PORT |-> !en_q[7])
    else $error("reserved enable bit stored");
  apb_ready_a: assert property (setup |=> (pready_o && penable_i) or !psel_i)
    else $error("access not answered in its first cycle");

  enable_write_c: cover property (wr_acc && acc_sel[2]);
  irq_raise_c: cover property (!irq_o ##1 irq_o);
  clear_race_c: cover property (|(event_i & flag_clr));
  bad_addr_c: cover property (pslverr_o && pready_o);

endmodule

`default_nettype wire

// [core/pie_pkg.sv]
// constants for the peripheral interrupt enable bank
// assumes a 32-bit apb slave port with a 12-bit byte address
package pie_pkg;

  localparam int unsigned PIE_ADDR_W = 12;
  localparam int unsigned PIE_DATA_W = 32;
  localparam int unsigned PIE_SRC_N = 8;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] PIE_OFF_CORE_CTL = 12'h080;
  localparam logic [11:0] PIE_OFF_FLAGS = 12'h084;
  localparam logic [11:0] PIE_OFF_ENABLES = 12'h08c;

  // ---------------------------------------------------------------
  // enable / flag bit positions
  // ---------------------------------------------------------------
  localparam int unsigned PIE_BIT_PAR_PORT = 7;
  localparam int unsigned PIE_BIT_CONV_DONE = 6;
  localparam int unsigned PIE_BIT_SERIAL_RX = 5;
  localparam int unsigned PIE_BIT_SERIAL_TX = 4;
  localparam int unsigned PIE_BIT_SYNC_SERIAL = 3;
  localparam int unsigned PIE_BIT_CAPCMP_ONE = 2;
  localparam int unsigned PIE_BIT_TIMER_TWO = 1;
  localparam int unsigned PIE_BIT_TIMER_ONE = 0;

  // core_irq_control fields
  localparam int unsigned PIE_BIT_GLOBAL_EN = 7;
  localparam int unsigned PIE_BIT_PERIPH_EN = 6;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] PIE_RST_ENABLES = 8'h00;
  localparam logic [7:0] PIE_RST_FLAGS = 8'h00;
  localparam logic [7:0] PIE_RST_CORE_CTL = 8'h00;

endpackage

// [core/pie_flag_bank.sv]
// sticky peripheral interrupt flags, one per source
// assumes set and clear pulses come from logic on clk_i
`timescale 1ns/1ps
`default_nettype none

module pie_flag_bank
  import pie_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [PIE_SRC_N-1:0] set_i,
  input wire logic [PIE_SRC_N-1:0] clr_i,
  output logic [PIE_SRC_N-1:0] flags_o
);

  logic [PIE_SRC_N-1:0] flags_q;
  logic [PIE_SRC_N-1:0] flags_d;

  // set beats clear so an event in the clearing cycle is kept
  for (genvar g = 0; g < PIE_SRC_N; g++) begin : g_flag
    assign flags_d[g] = set_i[g] | (flags_q[g] & ~clr_i[g]);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_q <= PIE_RST_FLAGS;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags_o = flags_q;

endmodule

`default_nettype wire

// [verif/peripheral_irq_enable_bank_tb_top.sv]
// self-checking bench for the peripheral interrupt enable bank
// assumes the bank answers each apb access; the watchdog ends a hang
`timescale 1ns/1ps
`default_nettype none

module peripheral_irq_enable_bank_tb_top;
  import pie_pkg::*;

  // variant under test carries the parallel port enable
  localparam bit HAS_PP = 1'b1;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0000_0000;
  logic [3:0] pst = 4'hf;
  logic [7:0] ev = 8'h00;
  logic [31:0] prd;
  logic prdy, perr, irq;
  logic [7:0] fl, en, fx, ctl;
  logic [7:0] lfsr = 8'h2f;
  logic [31:0] rd;
  logic er;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #2 clk_i = ~clk_i;

  pie_enable_bank #(.HAS_PAR_PORT(HAS_PP)) pie_enable_bank_i (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(pst),
    .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .event_i(ev), .flags_o(fl), .irq_o(irq)
  );

  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // request reaches the core only through all three gates
  function automatic logic exp_irq(input logic [7:0] f, input logic [7:0] e,
                                   input logic [7:0] c);
    return (|(f & e)) & c[PIE_BIT_GLOBAL_EN] & c[PIE_BIT_PERIPH_EN];
  endfunction

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // values are sampled before the edge's updates land
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    chk("pready_o latency", 32'd1, 32'(n));
  endtask

  task automatic pulse(input logic [7:0] v);
    @(posedge clk_i);
    ev <= v;
    @(posedge clk_i);
    ev <= 8'h00;
  endtask

  task automatic chk_irq(input logic e);
    repeat (3) @(posedge clk_i);
    chk("irq_o", {31'h0, e}, {31'h0, irq});
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b0, PIE_OFF_ENABLES, 32'h0);
    chk("enables reset", {24'h0, PIE_RST_ENABLES}, rd);
    apb(1'b0, 12'h0f0, 32'h0);
    chk("pslverr_o", 32'h1, {31'h0, er});
    $display("test reset and decode done");
    apb(1'b1, PIE_OFF_CORE_CTL, 32'h0000_00c0);
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, PIE_OFF_ENABLES, ~(32'h1 << k) & 32'hff);
      pulse(8'h01 << k);
      chk_irq(1'b0);
      apb(1'b0, PIE_OFF_FLAGS, 32'h0);
      chk("flags", 32'h1 << k, rd);
      apb(1'b1, PIE_OFF_ENABLES, 32'h1 << k);
      chk_irq(1'b1);
      apb(1'b1, PIE_OFF_FLAGS, 32'h1 << k);
      chk_irq(1'b0);
    end
    $display("test per-source gating done");
    // event and write-one-to-clear on one edge: the event wins
    pulse(8'h18);
    fork
      apb(1'b1, PIE_OFF_FLAGS, 32'h0000_0018);
      begin
        repeat (2) @(posedge clk_i);
        ev <= 8'h10;
        @(posedge clk_i);
        ev <= 8'h00;
      end
    join
    apb(1'b0, PIE_OFF_FLAGS, 32'h0);
    chk("flags race", 32'h10, rd);
    apb(1'b1, PIE_OFF_FLAGS, 32'hff);
    $display("test set against clear done");
    // strobe-less write must leave the enables alone
    pst <= 4'h0;
    apb(1'b1, PIE_OFF_ENABLES, 32'hff);
    pst <= 4'hf;
    apb(1'b0, PIE_OFF_ENABLES, 32'h0);
    chk("enables no strobe", 32'h80, rd);
    for (int i = 0; i < 24; i++) begin
      ctl = {2'(i), 6'h00};
      apb(1'b1, PIE_OFF_CORE_CTL, {24'h0, ctl});
      lfsr = nxt(lfsr);
      en = lfsr & (HAS_PP ? 8'hff : 8'h7f);
      apb(1'b1, PIE_OFF_ENABLES, {24'h0, en});
      apb(1'b0, PIE_OFF_ENABLES, 32'h0);
      chk("enables", {24'h0, en}, rd);
      lfsr = nxt(lfsr);
      fx = lfsr;
      pulse(fx);
      apb(1'b0, PIE_OFF_FLAGS, 32'h0);
      chk("flags", {24'h0, fx}, rd);
      chk("flags_o", {24'h0, fx}, {24'h0, fl});
      chk_irq(exp_irq(fx, en, ctl));
      apb(1'b1, PIE_OFF_FLAGS, 32'hff);
    end
    $display("test random gating done");
    tally_and_finish();
  end

endmodule

`default_nettype wire
